//--- src/conditional_move_decode.sv
// What this block does
// (RL1) Opcode 0F 46: move when carry or zero set; flags kept; one clock.
// (RL2) Opcode 0F 43: move when carry clear; flags kept; one clock.
// (RL3) Opcode 0F 42: move when carry set; flags kept; one clock.
// (RL4) Opcode 0F 44: move when zero set; flags kept; one clock.
// (RL5) Opcode 0F 45: move when zero clear; flags kept; one clock.
// (RL6) Opcode 0F 4F: move when zero clear and sign equals overflow; one clock.
// (RL7) Opcode 0F 4E: move when zero set or sign differs from overflow; one clock.
// (RL8) Opcode 0F 4C: move when sign differs from overflow; one clock.
// (RL9) Opcode 0F 4D: move when sign equals overflow; one clock.
// (RL10) Conditions come from carry, zero, sign and overflow in the usual way.
// (RL11) ModR/M reg picks destination, mod/rm picks source; false leaves destination.
`timescale 1ns/1ns
module conditional_move_decode (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire logic [7:0] escape_byte_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] modrm_in,
    input wire logic carry_flag_in,
    input wire logic zero_flag_in,
    input wire logic sign_flag_in,
    input wire logic overflow_flag_in,
    input wire logic [31:0] rm_reg_data_in,
    input wire logic [31:0] mem_data_in,
    output logic done_out,
    output logic claimed_out,
    output logic mem_source_out,
    output logic [2:0] rm_index_out,
    output logic wr_en_out,
    output logic [2:0] wr_reg_out,
    output logic [31:0] wr_data_out,
    output logic flags_we_out
);
    // ****************************************************************
    // Decode
    // ****************************************************************

    // Map the second opcode byte onto a condition; anything else is not ours
    function automatic condmove_pkg::cond_t decode_cond(input logic [7:0] esc, input logic [7:0] op);
        condmove_pkg::cond_t c;
        c = condmove_pkg::COND_NONE;
        if (esc == condmove_pkg::ESCAPE_BYTE) begin
            case (op)
                condmove_pkg::OP_BELOW: c = condmove_pkg::COND_BELOW;
                condmove_pkg::OP_ABOVE_OR_EQUAL: c = condmove_pkg::COND_ABOVE_OR_EQUAL;
                condmove_pkg::OP_EQUAL: c = condmove_pkg::COND_EQUAL;
                condmove_pkg::OP_NOT_EQUAL: c = condmove_pkg::COND_NOT_EQUAL;
                condmove_pkg::OP_BELOW_OR_EQUAL: c = condmove_pkg::COND_BELOW_OR_EQUAL;
                condmove_pkg::OP_LESS: c = condmove_pkg::COND_LESS;
                condmove_pkg::OP_GREATER_OR_EQUAL: c = condmove_pkg::COND_GREATER_OR_EQUAL;
                condmove_pkg::OP_LESS_OR_EQUAL: c = condmove_pkg::COND_LESS_OR_EQUAL;
                condmove_pkg::OP_GREATER: c = condmove_pkg::COND_GREATER;
                default: c = condmove_pkg::COND_NONE;
            endcase
        end
        return c;
    endfunction

    // Evaluate a condition against the arithmetic flags
    function automatic logic cond_holds(input condmove_pkg::cond_t c, input logic cf, input logic zf,
                                        input logic sf, input logic of_f);
        logic r;
        r = 1'b0;
        case (c)
            condmove_pkg::COND_BELOW: r = cf; // see (RL3) (RL10)
            condmove_pkg::COND_ABOVE_OR_EQUAL: r = !cf; // see (RL2)
            condmove_pkg::COND_EQUAL: r = zf; // see (RL4)
            condmove_pkg::COND_NOT_EQUAL: r = !zf; // see (RL5)
            condmove_pkg::COND_BELOW_OR_EQUAL: r = cf | zf; // see (RL1) (RL10)
            condmove_pkg::COND_LESS: r = sf ^ of_f; // see (RL8) (RL10)
            condmove_pkg::COND_GREATER_OR_EQUAL: r = !(sf ^ of_f); // see (RL9)
            condmove_pkg::COND_LESS_OR_EQUAL: r = zf | (sf ^ of_f); // see (RL7) (RL10)
            condmove_pkg::COND_GREATER: r = !zf & !(sf ^ of_f); // see (RL6)
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Combinational decode of the current instruction
    condmove_pkg::cond_t cond_w;
    wire logic ours_w;
    wire logic take_w;
    wire logic is_mem_w;
    wire logic [2:0] dest_w;
    wire logic [2:0] rm_w;
    wire logic [31:0] src_w;

    assign cond_w = decode_cond(escape_byte_in, opcode_in);
    assign ours_w = instr_valid_in && (cond_w != condmove_pkg::COND_NONE);
    assign take_w = ours_w && cond_holds(cond_w, carry_flag_in, zero_flag_in, sign_flag_in, overflow_flag_in);
    // Register source only for mod = 11, otherwise the fetched memory operand
    assign is_mem_w = modrm_in[condmove_pkg::MOD_HI:condmove_pkg::MOD_LO] != condmove_pkg::MOD_REGISTER; // see (RL11)
    assign dest_w = modrm_in[condmove_pkg::REG_HI:condmove_pkg::REG_LO]; // see (RL11)
    assign rm_w = modrm_in[condmove_pkg::RM_HI:condmove_pkg::RM_LO];
    assign src_w = is_mem_w ? mem_data_in : rm_reg_data_in;

    // ****************************************************************
    // Execute: one clock from acceptance to the write
    // ****************************************************************

    // A false condition still completes but raises no write enable, so the
    // destination keeps its value; the memory operand is still consumed.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            claimed_out <= 1'b0;
            mem_source_out <= 1'b0;
            rm_index_out <= condmove_pkg::REG_RESET;
            wr_en_out <= 1'b0;
            wr_reg_out <= condmove_pkg::REG_RESET;
            wr_data_out <= condmove_pkg::DATA_RESET;
            flags_we_out <= 1'b0;
        end else begin
            done_out <= ours_w; // see (RL1) (RL2) (RL3) (RL4) (RL5)
            claimed_out <= ours_w;
            mem_source_out <= ours_w && is_mem_w;
            rm_index_out <= rm_w;
            wr_en_out <= take_w; // see (RL11) (RL6) (RL7) (RL8) (RL9)
            wr_reg_out <= dest_w;
            wr_data_out <= src_w;
            flags_we_out <= 1'b0; // Flags are never written by these moves
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    // Every check triggered by an accepted instruction looks one clock later; flags are taken as they
    // stood at acceptance, since a later flag change must not alter the result
    a_below_eq_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL1)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_BELOW_OR_EQUAL)
        |=> (done_out && !flags_we_out && wr_en_out == ($past(carry_flag_in) | $past(zero_flag_in))))
        else $error("below-or-equal move wrong");

    a_above_eq_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL2)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_ABOVE_OR_EQUAL)
        |=> (done_out && wr_en_out == !$past(carry_flag_in)))
        else $error("above-or-equal move wrong");

    a_below_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL3)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_BELOW && carry_flag_in)
        |=> (wr_en_out && wr_data_out == (($past(modrm_in[condmove_pkg::MOD_HI:condmove_pkg::MOD_LO])
                                           == condmove_pkg::MOD_REGISTER) ? $past(rm_reg_data_in)
                                                                          : $past(mem_data_in))))
        else $error("below move did not write source");

    a_equal_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL4)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_EQUAL)
        |=> (wr_en_out == $past(zero_flag_in)))
        else $error("equal move wrong");

    a_not_equal_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL5)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_NOT_EQUAL && zero_flag_in)
        |=> (done_out && !wr_en_out))
        else $error("not-equal move wrote on zero");

    a_greater_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL6)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE && opcode_in == condmove_pkg::OP_GREATER)
        |=> (wr_en_out == (!$past(zero_flag_in) && ($past(sign_flag_in) == $past(overflow_flag_in)))))
        else $error("greater move wrong");

    a_less_eq_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL7)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_LESS_OR_EQUAL)
        |=> (wr_en_out == ($past(zero_flag_in) || ($past(sign_flag_in) != $past(overflow_flag_in)))))
        else $error("less-or-equal move wrong");

    a_less_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL8)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE && opcode_in == condmove_pkg::OP_LESS)
        |=> (wr_en_out == ($past(sign_flag_in) ^ $past(overflow_flag_in))))
        else $error("less move wrong");

    a_greater_eq_move: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL9)
        (instr_valid_in && escape_byte_in == condmove_pkg::ESCAPE_BYTE
         && opcode_in == condmove_pkg::OP_GREATER_OR_EQUAL)
        |=> (wr_en_out == ($past(sign_flag_in) == $past(overflow_flag_in))))
        else $error("greater-or-equal move wrong");

    a_write_needs_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL10)
        wr_en_out |-> (done_out && !flags_we_out))
        else $error("write without completion or with flag write");

    a_modrm_routing: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL11)
        ours_w |=> (wr_reg_out == $past(modrm_in[condmove_pkg::REG_HI:condmove_pkg::REG_LO])
                    && rm_index_out == $past(modrm_in[condmove_pkg::RM_HI:condmove_pkg::RM_LO])
                    && mem_source_out == ($past(modrm_in[condmove_pkg::MOD_HI:condmove_pkg::MOD_LO])
                                          != condmove_pkg::MOD_REGISTER)))
        else $error("modrm routing wrong");

    // Register form: the r/m register value is what gets written
    a_reg_source: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL11)
        (ours_w && modrm_in[condmove_pkg::MOD_HI:condmove_pkg::MOD_LO] == condmove_pkg::MOD_REGISTER)
        |=> (!mem_source_out && wr_data_out == $past(rm_reg_data_in)))
        else $error("register source not routed");

    // Memory form: the fetched operand is what gets written
    a_mem_source: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL11)
        (ours_w && modrm_in[condmove_pkg::MOD_HI:condmove_pkg::MOD_LO] != condmove_pkg::MOD_REGISTER)
        |=> (mem_source_out && wr_data_out == $past(mem_data_in)))
        else $error("memory source not routed");

    // A cycle that is invalid or lacks the escape byte must leave every pulse low on the next edge
    a_refused_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL11)
        (!instr_valid_in || escape_byte_in != condmove_pkg::ESCAPE_BYTE)
        |=> (!done_out && !claimed_out && !wr_en_out && !mem_source_out))
        else $error("unclaimed cycle produced output");

    // Flags belong to the flag datapath; this block never asks for a write
    a_flags_kept: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL1)
        !flags_we_out)
        else $error("flag write requested");

    // Claim and completion are one pulse, so retire logic may use either
    a_claim_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see (RL11)
        claimed_out == done_out)
        else $error("claim and completion disagree");

endmodule // conditional_move_decode

//--- pkg/condmove_pkg.sv
package condmove_pkg;
    // ****************************************************************
    // Opcode bytes
    // ****************************************************************
    localparam logic [7:0] ESCAPE_BYTE = 8'h0f;
    localparam logic [7:0] OP_BELOW = 8'h42;
    localparam logic [7:0] OP_ABOVE_OR_EQUAL = 8'h43;
    localparam logic [7:0] OP_EQUAL = 8'h44;
    localparam logic [7:0] OP_NOT_EQUAL = 8'h45;
    localparam logic [7:0] OP_BELOW_OR_EQUAL = 8'h46;
    localparam logic [7:0] OP_LESS = 8'h4c;
    localparam logic [7:0] OP_GREATER_OR_EQUAL = 8'h4d;
    localparam logic [7:0] OP_LESS_OR_EQUAL = 8'h4e;
    localparam logic [7:0] OP_GREATER = 8'h4f;

    // ****************************************************************
    // ModR/M field layout
    // ****************************************************************
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int REG_HI = 5;
    localparam int REG_LO = 3;
    localparam int RM_HI = 2;
    localparam int RM_LO = 0;
    localparam logic [1:0] MOD_REGISTER = 2'h3;

    // ****************************************************************
    // Widths, timing and reset values
    // ****************************************************************
    localparam int DATA_W = 32;
    localparam int REG_IDX_W = 3;
    localparam int EXEC_CLOCKS = 1;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [REG_IDX_W-1:0] REG_RESET = 3'h0;

    // Conditions handled by this block
    typedef enum {
        COND_NONE,
        COND_BELOW,
        COND_ABOVE_OR_EQUAL,
        COND_EQUAL,
        COND_NOT_EQUAL,
        COND_BELOW_OR_EQUAL,
        COND_LESS,
        COND_GREATER_OR_EQUAL,
        COND_LESS_OR_EQUAL,
        COND_GREATER
    } cond_t;
endpackage

//--- sim/tb_conditional_move_decode.sv
`timescale 1ns/1ns
module tb_conditional_move_decode;
    // ****************************************************************
    // Stimulus and observed ports
    // ****************************************************************
    logic mclk_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0;
    logic [7:0] escape_byte_in = 8'h00, opcode_in = 8'h00, modrm_in = 8'h00;
    logic carry_flag_in = 1'b0, zero_flag_in = 1'b0, sign_flag_in = 1'b0, overflow_flag_in = 1'b0;
    logic [31:0] rm_reg_data_in = 32'h0, mem_data_in = 32'h0, wr_data_out;
    logic done_out, claimed_out, mem_source_out, wr_en_out, flags_we_out;
    logic [2:0] rm_index_out, wr_reg_out;
    int err_count = 0, tests_run = 0, cycles = 0;
    logic [7:0] ops [9] = '{condmove_pkg::OP_BELOW, condmove_pkg::OP_ABOVE_OR_EQUAL, condmove_pkg::OP_EQUAL,
        condmove_pkg::OP_NOT_EQUAL, condmove_pkg::OP_BELOW_OR_EQUAL, condmove_pkg::OP_LESS,
        condmove_pkg::OP_GREATER_OR_EQUAL, condmove_pkg::OP_LESS_OR_EQUAL, condmove_pkg::OP_GREATER};

    conditional_move_decode i_conditional_move_decode (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .instr_valid_in(instr_valid_in), .escape_byte_in(escape_byte_in), .opcode_in(opcode_in),
        .modrm_in(modrm_in), .carry_flag_in(carry_flag_in), .zero_flag_in(zero_flag_in),
        .sign_flag_in(sign_flag_in), .overflow_flag_in(overflow_flag_in), .rm_reg_data_in(rm_reg_data_in),
        .mem_data_in(mem_data_in), .done_out(done_out), .claimed_out(claimed_out),
        .mem_source_out(mem_source_out), .rm_index_out(rm_index_out), .wr_en_out(wr_en_out),
        .wr_reg_out(wr_reg_out), .wr_data_out(wr_data_out), .flags_we_out(flags_we_out));

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask

    // Expected condition from flags f = {carry, zero, sign, overflow}
    function automatic logic cond_of(input logic [7:0] op, input logic [3:0] f);
        case (op)
            8'h42: return f[3];
            8'h43: return !f[3];
            8'h44: return f[2];
            8'h45: return !f[2];
            8'h46: return f[3] | f[2];
            8'h4c: return f[1] ^ f[0];
            8'h4d: return !(f[1] ^ f[0]);
            8'h4e: return f[2] | (f[1] ^ f[0]);
            default: return !f[2] & !(f[1] ^ f[0]);
        endcase
    endfunction

    // One instruction, then one idle edge so the pulse is seen alone
    task automatic issue(input logic v, input logic [7:0] esc, op, mrm, input logic [3:0] f,
        input logic [31:0] rd, md);
        @(posedge mclk_in);
        instr_valid_in <= v;
        escape_byte_in <= esc;
        opcode_in <= op;
        modrm_in <= mrm;
        {carry_flag_in, zero_flag_in, sign_flag_in, overflow_flag_in} <= f;
        rm_reg_data_in <= rd;
        mem_data_in <= md;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_all_conditions;
        logic e;
        for (int i = 0; i < 9; i++) begin
            for (int f = 0; f < 16; f++) begin
                e = cond_of(ops[i], f[3:0]);
                issue(1'b1, condmove_pkg::ESCAPE_BYTE, ops[i], {2'h3, f[2:0], 3'h5}, f[3:0], {24'h0, i[3:0], f[3:0]},
                    32'hffff_ffff);
                chk({done_out, claimed_out}, 2'h3);
                chk(wr_en_out, e);
                chk(flags_we_out, 1'b0);
                chk({mem_source_out, rm_index_out, wr_reg_out}, {1'b0, 3'h5, f[2:0]});
                if (e) chk(wr_data_out, {24'h0, i[3:0], f[3:0]});
            end
        end
    endtask

    // Memory source for every non-register mod when taken, and for mods 0 and 1 when not taken
    task automatic t_memory_source;
        for (int m = 0; m < 6; m++) begin
            issue(1'b1, condmove_pkg::ESCAPE_BYTE, condmove_pkg::OP_EQUAL, {m[1:0] % 2'h3, 3'h6, 3'h2},
                {1'b0, m < 3, 2'h0}, 32'h1111_1111, 32'hcafe_0000 | m);
            chk({done_out, mem_source_out, wr_en_out}, {2'h3, m < 3});
            chk({rm_index_out, wr_reg_out}, 6'h16);
            if (m < 3) chk(wr_data_out, 32'hcafe_0000 | m);
        end
    endtask

    // Foreign opcode, wrong escape byte and invalid cycle give nothing
    task automatic t_refused;
        issue(1'b1, 8'h0f, 8'h47, 8'hc0, 4'hf, 32'h1, 32'h2);
        chk({done_out, claimed_out, wr_en_out}, 3'h0);
        issue(1'b1, 8'h0e, 8'h44, 8'hc0, 4'hf, 32'h1, 32'h2);
        chk({done_out, claimed_out, wr_en_out}, 3'h0);
        issue(1'b0, 8'h0f, 8'h44, 8'hc0, 4'hf, 32'h1, 32'h2);
        chk({done_out, claimed_out, wr_en_out}, 3'h0);
    endtask

    // Two instructions on adjacent edges each answer one clock later
    task automatic t_back_to_back;
        @(posedge mclk_in);
        {instr_valid_in, escape_byte_in, opcode_in, modrm_in} <= {1'b1, 16'h0f44, 8'hc8};
        {zero_flag_in, rm_reg_data_in} <= {1'b1, 32'haaaa_0001};
        @(posedge mclk_in);
        {opcode_in, modrm_in, zero_flag_in, rm_reg_data_in} <= {16'h45d0, 1'b0, 32'hbbbb_0002};
        #1;
        chk({done_out, wr_en_out, wr_reg_out, wr_data_out}, {2'h3, 3'h1, 32'haaaa_0001});
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({done_out, wr_en_out, wr_reg_out, wr_data_out}, {2'h3, 3'h2, 32'hbbbb_0002});
        @(posedge mclk_in);
        #1;
        chk({done_out, wr_en_out}, 2'h0);
    endtask

    // ****************************************************************
    // Clock, run control and verdict
    // ****************************************************************
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    // Whole run is well under 500 cycles; the ceiling leaves ample margin
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_all_conditions();
        t_memory_source();
        t_refused();
        t_back_to_back();
        end_of_test();
    end
endmodule // tb_conditional_move_decode
